/* eeas_master_model.sv */
// Two-wire bus master model, SCL period 16 system clocks
`timescale 1ns/1ps
module eeas_master_model (
  input  wire logic clk,     // system clock
  input  wire logic sdaLine, // resolved SDA
  output logic      scl,     // serial clock, idles high
  output logic      sdaLow   // master pulls SDA low
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    sdaLow <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sdaLow <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sdaLow <= 1'b0;
    tick(8);
  endtask
  task automatic bitIo(input logic b, output logic s);
    sdaLow <= !b;
    tick(4);
    scl <= 1'b1;
    tick(8);
    s = sdaLine;
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(d[i], s);
    bitIo(1'b1, s);
    ack = !s;
  endtask
  task automatic recvByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(!ack, s);
  endtask
endmodule

/* eeas_pkg.sv */
// Package: constants and carrier types for the two-wire EEPROM addressing front end
package eeas_pkg;
  localparam int          CLK_MHZ        = 200;
  localparam int          WRITE_CYCLE_MS = 10;
  localparam int          WRITE_CYCLES   = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  localparam logic [3:0]  DEV_TYPE       = 4'hA;
  localparam int          BITS_PER_BYTE  = 8;
  localparam int          PAGE_BYTES     = 16;
  localparam int          BLOCK_BYTES    = 256;
  localparam int          ADDR_PROT_BIT  = 7;
  localparam logic [2:0]  BIT_LAST       = 3'h7;

  // AHB-Lite register offsets
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_LASTADDR   = 8'h08;
  localparam logic [7:0]  REG_MEMADDR    = 8'h0C;
  localparam logic [7:0]  REG_MEMDATA    = 8'h10;

  typedef enum logic [1:0] {EEAS_IDLE, EEAS_RX, EEAS_ACK, EEAS_TX} eeas_phase_type;

  typedef struct packed {
    logic        busy;
    logic        writeMode;
    logic        selected;
    logic [7:0]  arrayAddr;
  } eeas_status_type;

  typedef struct packed {
    logic [2:0]  selectPins;
    logic        writeProtect;
  } eeas_pins_type;
endpackage

/* eeas_slave.sv */
// Two-wire EEPROM slave: addressing, acknowledge, array, write protect, AHB-Lite view
`timescale 1ns/1ps
// Function
// - Slave address: type, select, direction
// - Type field must equal 1010
// - Select field must match select pins
// - Absent select pins choose page block
// - Last address bit: 1 read, 0 write
// - Receiver pulls SDA low on ninth clock
// - Transmitter releases SDA, samples acknowledge
// - Missing master acknowledge ends read
// - Accept 8-bit array address after ack
// - Pages of 16 bytes, rollover within
// - SDA only pulled low or released
// - SCL alone times every bit
// - Write protect guards upper half
// - Protected write: data byte not acknowledged
// - Unprotected: whole array read/write
// - Floating protect input counts low
// - Page block 256 bytes, one to eight
// - START is SDA falling, SCL high
// - STOP is SDA rising, SCL high
// - Busy for write cycle, no ack
module eeas_slave
  import eeas_pkg::*;
#(
  parameter int NUM_BLOCKS   = 1,              // page blocks, 1..8, power of two
  parameter int WRITE_CYCLES_P = eeas_pkg::WRITE_CYCLES // write cycle length in clocks
)(
  input  wire logic                  clk,          // system clock 200 MHz
  input  wire logic                  reset,        // synchronous, active high
  input  wire logic                  sclIn,        // serial clock from master
  input  wire logic                  sdaIn,        // serial data line level
  output logic                       sdaOut,       // always low when driven
  output logic                       sdaOe,        // high pulls SDA low
  input  wire eeas_pkg::eeas_pins_type pins,       // select pins and write protect
  input  wire logic                  hsel,         // AHB select
  input  wire logic [31:0]           haddr,        // AHB address
  input  wire logic [1:0]            htrans,       // AHB transfer type
  input  wire logic                  hwrite,       // AHB write
  input  wire logic [2:0]            hsize,        // AHB size
  input  wire logic [31:0]           hwdata,       // AHB write data
  input  wire logic                  hready,       // AHB bus ready
  output logic [31:0]                hrdata,       // AHB read data
  output logic                       hreadyout,    // AHB slave ready
  output logic                       hresp         // AHB response, always OKAY
);
  import eeas_pkg::*;

  localparam int BLK_BITS = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 0;
  localparam int MEM_BYTES = NUM_BLOCKS * BLOCK_BYTES;
  localparam int MA_BITS = $clog2(MEM_BYTES);

  initial begin
    if (NUM_BLOCKS < 1 || NUM_BLOCKS > 8 || (NUM_BLOCKS & (NUM_BLOCKS - 1)) != 0)
      $error("eeas_slave: NUM_BLOCKS must be 1, 2, 4 or 8");
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // The serial lines and the pins arrive with no timing relation to clk.
  // Two flops on each keep the engine free of metastable samples, which
  // costs about two clocks of latency on every serial edge.
  // Only the second flop of each pair feeds logic.
  logic [1:0] sclSync, sdaSync;
  logic [2:0] selSync0, selSync;
  logic       wpSync0, wpSync;
  logic       sclPrev, sdaPrev;

  always_ff @(posedge clk) begin
    sclSync  <= {sclSync[0], sclIn};
    sdaSync  <= {sdaSync[0], sdaIn};
    selSync0 <= pins.selectPins;
    selSync  <= selSync0;
    wpSync0  <= pins.writeProtect;
    wpSync   <= wpSync0;
    sclPrev  <= sclSync[1];
    sdaPrev  <= sdaSync[1];
  end

  wire scl     = sclSync[1];
  wire sda     = sdaSync[1];
  wire sclRise = scl & ~sclPrev;
  wire sclFall = ~scl & sclPrev;
  wire startCond = scl & sclPrev & sdaPrev & ~sda;
  wire stopCond  = scl & sclPrev & ~sdaPrev & sda;
  // Pull-down on the pin: only a hard high enables protection
  wire protectOn = (wpSync === 1'b1);

  // ==========================================================================
  // Serial engine
  // ==========================================================================
  // Bits are taken on a synced SCL rise and launched after a synced fall,
  // so SDA from this side only moves while SCL is low.
  // A START or STOP seen anywhere restarts or ends the transfer.
  // The acknowledge is decided at the eighth rise but only driven once
  // SCL has fallen, and it is held until the ninth clock has fallen.
  eeas_phase_type phase;
  logic [2:0]  bitCnt;
  logic [7:0]  shiftReg;
  logic [1:0]  byteIdx;      // 0 slave addr, 1 array addr, 2 data
  logic        selected, readMode, ackDrive, masterNak;
  logic [7:0]  arrayAddr;
  logic [2:0]  blockSel;
  logic [7:0]  lastSlaveAddr;
  logic        pendWrite, busy;
  logic [31:0] busyCnt;
  logic [7:0]  mem [MEM_BYTES];
  logic [7:0]  txByte;
  logic        ackWait;      // Acknowledge decided, waiting for SCL low
  logic        ackArm;       // Acknowledge decision for this byte

  // ==========================================================================
  // Slave address decode
  // ==========================================================================
  wire [7:0] rxByte   = {shiftReg[6:0], sda};
  wire       typeOk   = (rxByte[7:4] == DEV_TYPE);
  wire [2:0] pinMask  = 3'h7 << BLK_BITS;
  wire       selOk    = ((rxByte[3:1] ^ selSync) & pinMask) == 3'h0;
  wire       addrHit  = typeOk & selOk & ~busy;
  wire       protHit  = protectOn & arrayAddr[ADDR_PROT_BIT];
  wire [MA_BITS-1:0] memIdx = MA_BITS'({blockSel, arrayAddr});
  wire [7:0] nextInPage = {arrayAddr[7:4], 4'(arrayAddr[3:0] + 4'h1)};
  wire       rxAckBit = (bitCnt == BIT_LAST) & sclRise;

  always_ff @(posedge clk) begin
    if (reset) begin
      phase     <= EEAS_IDLE;
      bitCnt    <= 3'h0;
      shiftReg  <= 8'h00;
      byteIdx   <= 2'h0;
      selected  <= 1'b0;
      readMode  <= 1'b0;
      ackDrive  <= 1'b0;
      masterNak <= 1'b0;
      arrayAddr <= 8'h00;
      blockSel  <= 3'h0;
      lastSlaveAddr <= 8'h00;
      pendWrite <= 1'b0;
      txByte    <= 8'hFF;
      ackWait   <= 1'b0;
      ackArm    <= 1'b0;
    end else if (startCond) begin
      phase    <= EEAS_RX;
      bitCnt   <= 3'h0;
      byteIdx  <= 2'h0;
      selected <= 1'b0;
      ackDrive <= 1'b0;
      ackWait  <= 1'b0;
    end else if (stopCond) begin
      phase    <= EEAS_IDLE;
      selected <= 1'b0;
      ackDrive <= 1'b0;
      ackWait  <= 1'b0;
    end else begin
      case (phase)
        EEAS_IDLE: begin
          ackDrive <= 1'b0;
        end
        EEAS_RX: begin
          if (sclRise) begin
            shiftReg <= rxByte;
            bitCnt   <= bitCnt + 3'h1;
          end
          if (rxAckBit) begin
            if (byteIdx == 2'h0) begin
              lastSlaveAddr <= rxByte;
              selected <= addrHit;
              readMode <= rxByte[0];
              blockSel <= rxByte[3:1] & ~pinMask;
              ackArm   <= addrHit;
              ackWait  <= addrHit;
              phase    <= addrHit ? EEAS_ACK : EEAS_IDLE;
            end else if (byteIdx == 2'h1) begin
              arrayAddr <= rxByte;
              ackArm    <= 1'b1;
              ackWait   <= 1'b1;
              phase     <= EEAS_ACK;
            end else if (protHit) begin
              ackDrive <= 1'b0;
              phase    <= EEAS_IDLE;
            end else begin
              mem[memIdx] <= rxByte;
              arrayAddr <= nextInPage;
              pendWrite <= 1'b1;
              ackArm    <= 1'b1;
              ackWait   <= 1'b1;
              phase     <= EEAS_ACK;
            end
          end
        end
        EEAS_ACK: begin
          if (ackWait) begin
            // Pulling SDA while the eighth clock is still high would
            // look like a START on the bus, so wait for SCL low
            if (sclFall) begin
              ackDrive <= ackArm;
              ackWait  <= 1'b0;
            end
          end else begin
            // Acknowledge held low across the whole ninth clock
            if (sclRise && !readMode) begin
              if (byteIdx != 2'h2)
                byteIdx <= byteIdx + 2'h1;
            end
            if (sclFall) begin
              if (ackDrive || readMode) begin
                ackDrive <= 1'b0;
                bitCnt   <= 3'h0;
                if (readMode) begin
                  txByte <= mem[memIdx];
                  phase  <= EEAS_TX;
                end else begin
                  phase <= EEAS_RX;
                end
              end
            end
          end
        end
        EEAS_TX: begin
          if (sclFall) begin
            if (bitCnt == BIT_LAST) begin
              phase <= EEAS_ACK;
              ackDrive <= 1'b0;
            end else begin
              txByte <= {txByte[6:0], 1'b1};
            end
            bitCnt <= bitCnt + 3'h1;
          end
          if (sclRise && bitCnt == BIT_LAST) begin
            arrayAddr <= 8'(arrayAddr + 8'h01);
            masterNak <= 1'b0;
          end
        end
        default: phase <= EEAS_IDLE;
      endcase
      // Read: sample master acknowledge on the ninth clock
      if (phase == EEAS_ACK && readMode && sclRise) begin
        masterNak <= sda;
        if (sda)
          phase <= EEAS_IDLE;
      end
    end
    if (!reset && busy)
      pendWrite <= 1'b0;
  end

  // ==========================================================================
  // Internal write cycle timer
  // ==========================================================================
  // Starts only on a STOP that follows an acknowledged data byte.
  // While it runs the slave address is not acknowledged, which is what
  // a master polling for completion relies on.
  always_ff @(posedge clk) begin
    if (reset) begin
      busy    <= 1'b0;
      busyCnt <= 32'h0;
    end else if (stopCond && pendWrite && !busy) begin
      busy    <= 1'b1;
      busyCnt <= 32'(WRITE_CYCLES_P);
    end else if (busy) begin
      busyCnt <= busyCnt - 32'h1;
      if (busyCnt == 32'h1)
        busy <= 1'b0;
    end
  end

  // ==========================================================================
  // SDA open-drain output
  // ==========================================================================
  // Registered enable keeps glitches off the wired line; the pad only
  // ever pulls low, the bus pull-up supplies the high level.
  wire txLow = (phase == EEAS_TX) & ~txByte[7];
  always_ff @(posedge clk) begin
    if (reset)
      sdaOe <= 1'b0;
    else
      sdaOe <= ackDrive | txLow;
  end
  assign sdaOut = 1'b0;

  // ==========================================================================
  // AHB-Lite slave: status view and control
  // ==========================================================================
  logic        dWrite;
  logic [7:0]  dAddr;
  logic [7:0]  hostMemAddr;
  eeas_status_type status;

  wire addrValid = hsel & hready & htrans[1];
  assign status  = '{busy: busy, writeMode: ~readMode, selected: selected,
                     arrayAddr: arrayAddr};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk) begin
    if (reset) begin
      dWrite <= 1'b0;
      dAddr  <= 8'h00;
    end else begin
      dWrite <= addrValid & hwrite;
      dAddr  <= haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      hostMemAddr <= 8'h00;
    else if (dWrite && dAddr == REG_MEMADDR)
      hostMemAddr <= hwdata[7:0];
  end

  wire [MA_BITS-1:0] hostIdx = MA_BITS'(hostMemAddr);
  // Read data is chosen in the address phase and registered there, so it
  // stands through the whole data phase with no wait state
  wire [7:0] rdAddr   = haddr[7:0];
  wire       rdStatus = (rdAddr == REG_STATUS);
  wire       rdLast   = (rdAddr == REG_LASTADDR);
  wire       rdMemA   = (rdAddr == REG_MEMADDR);
  wire       rdMemD   = (rdAddr == REG_MEMDATA);
  wire       rdCtrl   = (rdAddr == REG_CTRL);
  wire [31:0] rdMux =
      rdStatus ? {21'h0, status} :
      rdLast   ? {24'h0, lastSlaveAddr} :
      rdMemA   ? {24'h0, hostMemAddr} :
      rdMemD   ? {24'h0, mem[hostIdx]} :
      rdCtrl   ? {28'h0, protectOn, selSync} : 32'h0;

  always_ff @(posedge clk) begin
    if (reset)
      hrdata <= 32'h0;
    else if (addrValid && !hwrite)
      hrdata <= rdMux;
  end
endmodule

/* eeas_slave_checker.sv */
// Checker: port-level properties of the two-wire EEPROM slave
`timescale 1ns/1ps
module eeas_slave_checker
  import eeas_pkg::*;
(
  input wire logic          clk,       // system clock
  input wire logic          reset,     // sync reset
  input wire logic          sclIn,     // serial clock
  input wire logic          sdaIn,     // line level
  input wire logic          sdaOut,    // pull value
  input wire logic          sdaOe,     // pull enable
  input wire eeas_pins_type pins,      // select and protect
  input wire logic          hsel,      // AHB select
  input wire logic [31:0]   haddr,     // AHB address
  input wire logic [1:0]    htrans,    // AHB transfer
  input wire logic          hwrite,    // AHB write
  input wire logic          hready,    // AHB ready
  input wire logic [31:0]   hrdata,    // AHB read data
  input wire logic          hreadyout, // AHB slave ready
  input wire logic          hresp      // AHB response
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire rdReq = hsel && hready && htrans[1] && !hwrite;
  // ==========================================
  // Serial line
  sda_only_low_a: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("device drives SDA high");
  oe_change_low_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("SDA changed while SCL high");
  oe_rise_low_a: assert property ($rose(sdaOe) |-> $past(!sclIn))
    else $error("SDA pulled without SCL low");
  ack_hold_a: assert property (sdaOe && sclIn |=> sdaOe || !sclIn)
    else $error("SDA released during SCL high");
  // ==========================================
  // Register bus
  ready_high_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not OKAY");
  ctrl_read_a: assert property (rdReq && haddr[7:0] == 8'h00 |=>
    hrdata[3:0] == {$past(pins.writeProtect), $past(pins.selectPins)})
    else $error("control read wrong");
  unmapped_read_a: assert property (rdReq && haddr[7:0] == 8'h20 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  hrdata_hold_a: assert property ($changed(hrdata) |-> $past(rdReq))
    else $error("hrdata changed without read");
endmodule
bind eeas_slave eeas_slave_checker i_eeas_slave_checker (.clk(clk), .reset(reset),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .pins(pins), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));

/* eeas_slave_tb.sv */
// Testbench: addressing, acknowledge, page rollover, protect, busy
`timescale 1ns/1ps
module eeas_slave_tb;
  import eeas_pkg::*;
  localparam logic [2:0] SEL = 3'h5;
  logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, sdaOut, sdaOe, scl, mLow, a;
  logic [7:0] d;
  eeas_pins_type pins = '{selectPins: SEL, writeProtect: 1'b0};
  int fails = 0, checkCount = 0, cyc = 0;
  wire sdaLine = !(mLow || (sdaOe && !sdaOut));
  eeas_slave #(.NUM_BLOCKS(1), .WRITE_CYCLES_P(200)) i_eeas_slave (.clk(clk),
    .reset(reset), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .pins(pins), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  eeas_master_model i_eeas_master_model (.clk(clk), .sdaLine(sdaLine), .scl(scl),
    .sdaLow(mLow));
  initial forever #2.5 clk = !clk;
  always @(posedge clk) if (++cyc == 20000) begin
    fails++;
    stop_test();
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (!hreadyout);
    rd = hrdata;
  endtask
  task automatic memAt(input logic [7:0] ad, input logic [7:0] exp);
    logic [31:0] r;
    ahb(1'b1, REG_MEMADDR, {24'h0, ad}, r);
    ahb(1'b0, REG_MEMDATA, 32'h0, r);
    chk(r[7:0], exp);
  endtask
  task automatic addrDev(input logic [7:0] sa, input logic exp);
    i_eeas_master_model.start();
    i_eeas_master_model.sendByte(sa, a);
    chk(a, exp);
  endtask
  // ==========================================
  // Scenarios
  task automatic regsTest();
    logic [31:0] r;
    ahb(1'b1, REG_CTRL, 32'hFFFF_FFFF, r);
    ahb(1'b0, REG_CTRL, 32'h0, r);
    chk(r, {28'h0, 1'b0, SEL});
    ahb(1'b1, 8'h20, 32'h1234_5678, r);
    ahb(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
  endtask
  task automatic matchTest();
    logic [7:0] bad [4] = '{8'hBA, 8'h2A, 8'hA8, 8'hAE};
    foreach (bad[i]) begin
      addrDev(bad[i], 1'b0);
      i_eeas_master_model.stop();
    end
    addrDev({DEV_TYPE, SEL, 1'b0}, 1'b1);
    i_eeas_master_model.stop();
  endtask
  task automatic pageTest();
    logic [7:0] v [3] = '{8'h11, 8'h22, 8'h33};
    addrDev({DEV_TYPE, SEL, 1'b0}, 1'b1);
    i_eeas_master_model.sendByte(8'h8E, a);
    chk(a, 1'b1);
    foreach (v[i]) begin
      i_eeas_master_model.sendByte(v[i], a);
      chk(a, 1'b1);
    end
    i_eeas_master_model.stop();
    addrDev({DEV_TYPE, SEL, 1'b0}, 1'b0);
    i_eeas_master_model.stop();
    i_eeas_master_model.tick(200);
    memAt(8'h80, 8'h33);
    memAt(8'h8F, 8'h22);
    addrDev({DEV_TYPE, SEL, 1'b0}, 1'b1);
    i_eeas_master_model.sendByte(8'h8F, a);
    addrDev({DEV_TYPE, SEL, 1'b1}, 1'b1);
    i_eeas_master_model.recvByte(1'b0, d);
    chk(d, 8'h22);
    i_eeas_master_model.stop();
  endtask
  task automatic protectTest(input logic [7:0] ad, input logic expAck);
    pins.writeProtect <= 1'b1;
    addrDev({DEV_TYPE, SEL, 1'b0}, 1'b1);
    i_eeas_master_model.sendByte(ad, a);
    chk(a, 1'b1);
    i_eeas_master_model.sendByte(8'h5A, a);
    chk(a, expAck);
    i_eeas_master_model.stop();
    i_eeas_master_model.tick(300);
    memAt(ad, expAck ? 8'h5A : 8'h11);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    regsTest();
    matchTest();
    pageTest();
    protectTest(8'h8E, 1'b0);
    protectTest(8'h10, 1'b1);
    stop_test();
  end
endmodule
